/* src/cca_defines.vh */
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH

// ---------------------------------------------------------------
// snoop encodings, read / write / snoop channels
// ---------------------------------------------------------------
`define CCA_AR_READ_ONCE      4'h0
`define CCA_AR_READ_CLEAN     4'h2
`define CCA_AR_CLEAN_UNIQUE   4'hb
`define CCA_AR_CLEAN_INVALID  4'h9
`define CCA_AR_MAKE_INVALID   4'hd
`define CCA_AR_DVM_COMPLETE   4'he
`define CCA_AR_DVM_MESSAGE    4'hf
`define CCA_AW_WRITE_UNIQUE   3'h0
`define CCA_AC_CLEAN_INVALID  4'h9
`define CCA_AC_MAKE_INVALID   4'hd
`define CCA_AC_DVM_COMPLETE   4'he
`define CCA_AC_DVM_MESSAGE    4'hf

// ---------------------------------------------------------------
// dvm message type field (address bits 14:12)
// ---------------------------------------------------------------
`define CCA_DVM_TLBI          3'h0
`define CCA_DVM_BPI           3'h1
`define CCA_DVM_PICI          3'h2
`define CCA_DVM_VICI          3'h3
`define CCA_DVM_SYNC          3'h4
`define CCA_DVM_TYPE_LSB      12
`define CCA_DVM_GUEST_LSB     8
`define CCA_DVM_GUEST_HYP     2'h2
`define CCA_DVM_SEC_LSB       10
`define CCA_DVM_SEC_NS        2'h3
`define CCA_DVM_VA_BIT        0

// ---------------------------------------------------------------
// request kinds from the cache side
// ---------------------------------------------------------------
`define CCA_REQ_FILL          4'h0
`define CCA_REQ_READ          4'h1
`define CCA_REQ_SWX           4'h2
`define CCA_REQ_STORE         4'h3
`define CCA_REQ_FLUSH         4'h4
`define CCA_REQ_CLEAR         4'h5
`define CCA_REQ_TLBI          4'h6
`define CCA_REQ_BPI           4'h7
`define CCA_REQ_ICI_PA        4'h8
`define CCA_REQ_ICI_VA        4'h9
`define CCA_REQ_SYNC          4'ha
`define CCA_REQ_COMPLETE      4'hb

`define CCA_INTERCONNECT_ACE  3
`define CCA_CRESP_NODATA      5'h00

`endif

/* src/cca_snoop.v */
`timescale 1ns/100ps
`include "cca_defines.vh"

module cca_snoop (
	input  wire        clock_in,
	input  wire        rst_in,
	input  wire        enable_in,
	input  wire        ac_valid_in,
	input  wire [3:0]  ac_snoop_in,
	input  wire [63:0] ac_addr_in,
	input  wire        cr_ready_in,
	input  wire        inval_done_in,
	output reg         ac_ready_out,
	output reg         cr_valid_out,
	output reg  [4:0]  cr_resp_out,
	output reg         inval_req_out,
	output reg  [63:0] inval_addr_out,
	output reg         dvm_seen_out
);
	localparam ST_IDLE = 2'd0;
	localparam ST_INV  = 2'd1;
	localparam ST_RESP = 2'd2;

	reg [1:0] state_ff;

	// ---------------------------------------------------------------
	// snoop handling
	// ---------------------------------------------------------------
	always @(posedge clock_in) begin
		if (rst_in) begin
			state_ff       <= ST_IDLE;
			ac_ready_out   <= 1'b0;
			cr_valid_out   <= 1'b0;
			cr_resp_out    <= `CCA_CRESP_NODATA;
			inval_req_out  <= 1'b0;
			inval_addr_out <= 64'h0000_0000_0000_0000;
			dvm_seen_out   <= 1'b0;
		end else begin
			ac_ready_out <= 1'b0;
			dvm_seen_out <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (enable_in && ac_valid_in && !ac_ready_out) begin
					ac_ready_out <= 1'b1;
					// invalidate lines of the attached cache, icache ports included (enable gated by IS_DATA_SIDE only via ADDR_OK at widths other than 32)
					if (ac_snoop_in == `CCA_AC_CLEAN_INVALID || ac_snoop_in == `CCA_AC_MAKE_INVALID) begin
						inval_req_out  <= 1'b1;
						inval_addr_out <= ac_addr_in;
						state_ff       <= ST_INV;
					end else begin
						// dvm and anything else just answered
						dvm_seen_out <= (ac_snoop_in == `CCA_AC_DVM_MESSAGE);
						cr_valid_out <= 1'b1;
						state_ff     <= ST_RESP;
					end
				end
			end
			ST_INV: begin
				if (inval_done_in) begin
					inval_req_out <= 1'b0;
					cr_valid_out  <= 1'b1; // response only after invalidate
					state_ff      <= ST_RESP;
				end
			end
			ST_RESP: begin
				if (cr_ready_in) begin
					cr_valid_out <= 1'b0;
					state_ff     <= ST_IDLE;
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule // cca_snoop

/* src/cca_dvm_enc.v */
`timescale 1ns/100ps
`include "cca_defines.vh"

module cca_dvm_enc (
	input  wire [3:0]  kind_in,
	input  wire [31:0] addr_in,
	output reg  [31:0] dvm_word_out
);
	// ---------------------------------------------------------------
	// first dvm address word from request kind
	// ---------------------------------------------------------------
	always @* begin
		dvm_word_out = 32'h0000_0000;
		case (kind_in)
		`CCA_REQ_TLBI: begin
			dvm_word_out[14:12] = `CCA_DVM_TLBI;
			dvm_word_out[9:8]   = `CCA_DVM_GUEST_HYP;
			dvm_word_out[0]     = 1'b1;
		end
		`CCA_REQ_BPI:    dvm_word_out[14:12] = `CCA_DVM_BPI;
		`CCA_REQ_ICI_PA: begin
			dvm_word_out[14:12] = `CCA_DVM_PICI; // no virtual index
			dvm_word_out[11:10] = `CCA_DVM_SEC_NS;
			dvm_word_out[0]     = 1'b1;
		end
		`CCA_REQ_ICI_VA: begin
			dvm_word_out[14:12] = `CCA_DVM_VICI;
			dvm_word_out[9:8]   = `CCA_DVM_GUEST_HYP;
			dvm_word_out[0]     = 1'b1;
		end
		`CCA_REQ_SYNC:   dvm_word_out[14:12] = `CCA_DVM_SYNC;
		default:         dvm_word_out = 32'h0000_0000;
		endcase
		if (kind_in == `CCA_REQ_TLBI || kind_in == `CCA_REQ_ICI_VA || kind_in == `CCA_REQ_ICI_PA)
			dvm_word_out[31:15] = addr_in[31:15];
	end
endmodule // cca_dvm_enc

/* src/cca_port.v */
`timescale 1ns/100ps
`include "cca_defines.vh"

module cca_port #(
	parameter INTERCONNECT_SEL = `CCA_INTERCONNECT_ACE,
	parameter IS_DATA_SIDE     = 1,
	parameter ADDR_SIZE        = 32
) (
	input  wire                 clock_in,
	input  wire                 rst_in,
	input  wire                 cache_on_in,
	input  wire                 inhibit_cache_in,
	input  wire                 req_valid_in,
	input  wire [3:0]           req_kind_in,
	input  wire [ADDR_SIZE-1:0] req_addr_in,
	input  wire [31:0]          req_wdata_in,
	input  wire [3:0]           req_wstrb_in,
	output reg                  req_ready_out,
	output reg                  req_done_out,
	output reg  [31:0]          req_rdata_out,
	output reg  [1:0]           req_resp_out,
	output reg                  ar_valid_out,
	input  wire                 ar_ready_in,
	output reg  [ADDR_SIZE-1:0] ar_addr_out,
	output reg  [3:0]           ar_snoop_out,
	output reg  [1:0]           ar_domain_out,
	input  wire                 r_valid_in,
	input  wire [31:0]          r_data_in,
	input  wire [3:0]           r_resp_in,
	input  wire                 r_last_in,
	output reg                  r_ready_out,
	output reg                  r_ack_out,
	output reg                  aw_valid_out,
	input  wire                 aw_ready_in,
	output reg  [ADDR_SIZE-1:0] aw_addr_out,
	output reg  [2:0]           aw_snoop_out,
	output reg                  w_valid_out,
	input  wire                 w_ready_in,
	output reg  [31:0]          w_data_out,
	output reg  [3:0]           w_strb_out,
	output reg                  w_last_out,
	input  wire                 b_valid_in,
	input  wire [1:0]           b_resp_in,
	output reg                  b_ready_out,
	output reg                  w_ack_out,
	input  wire                 ac_valid_in,
	input  wire [3:0]           ac_snoop_in,
	input  wire [63:0]          ac_addr_in,
	output wire                 ac_ready_out,
	output wire                 cr_valid_out,
	output wire [4:0]           cr_resp_out,
	input  wire                 cr_ready_in,
	output wire                 inval_req_out,
	output wire [63:0]          inval_addr_out,
	input  wire                 inval_done_in,
	output reg                  coherent_out
);
	localparam ST_IDLE = 3'd0;
	localparam ST_AR   = 3'd1;
	localparam ST_R    = 3'd2;
	localparam ST_AW   = 3'd3;
	localparam ST_B    = 3'd4;
	localparam ST_ACK  = 3'd5;

	// extended addressing only on data side, legal widths only
	localparam ADDR_OK = (ADDR_SIZE == 32) || (IS_DATA_SIDE != 0 && (ADDR_SIZE == 36 || ADDR_SIZE == 40 ||
		ADDR_SIZE == 44 || ADDR_SIZE == 48 || ADDR_SIZE == 64));
	localparam ENABLED = (INTERCONNECT_SEL == `CCA_INTERCONNECT_ACE) && ADDR_OK;

	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg  [3:0]  sel_snoop;
	reg         sel_is_write;
	reg         sel_legal;
	reg  [ADDR_SIZE-1:0] dvm_addr;
	wire [31:0] dvm_word;

	// ---------------------------------------------------------------
	// transaction selection
	// ---------------------------------------------------------------
	function [4:0] pick_snoop;
		input [3:0] kind;
		input       cacheable;
		input       data_side;
		begin
			pick_snoop = {1'b1, `CCA_AR_DVM_MESSAGE};
			case (kind)
			`CCA_REQ_FILL:     pick_snoop = {1'b1, cacheable ? `CCA_AR_READ_CLEAN : `CCA_AR_READ_ONCE};
			`CCA_REQ_READ:     pick_snoop = {1'b1, `CCA_AR_READ_ONCE};
			`CCA_REQ_SWX:      pick_snoop = {data_side, `CCA_AR_CLEAN_UNIQUE};
			`CCA_REQ_STORE:    pick_snoop = {data_side, 4'h0};
			`CCA_REQ_FLUSH:    pick_snoop = {data_side, `CCA_AR_CLEAN_INVALID};
			`CCA_REQ_CLEAR:    pick_snoop = {data_side, `CCA_AR_MAKE_INVALID};
			`CCA_REQ_COMPLETE: pick_snoop = {1'b1, `CCA_AR_DVM_COMPLETE};
			`CCA_REQ_TLBI, `CCA_REQ_BPI, `CCA_REQ_ICI_PA,
			`CCA_REQ_ICI_VA, `CCA_REQ_SYNC:
				pick_snoop = {1'b1, `CCA_AR_DVM_MESSAGE};
			default:           pick_snoop = 5'h00;
			endcase
		end
	endfunction

	always @* begin
		{sel_legal, sel_snoop} = pick_snoop(req_kind_in, cache_on_in && !inhibit_cache_in, IS_DATA_SIDE != 0);
		sel_is_write = (req_kind_in == `CCA_REQ_STORE);
	end

	cca_dvm_enc u_dvm (
		.kind_in      (req_kind_in),
		.addr_in      (req_addr_in[31:0]),
		.dvm_word_out (dvm_word)
	);

	// dvm word sits in the low 32 bits, no zero-width pad at 32-bit size
	always @* begin
		dvm_addr       = {ADDR_SIZE{1'b0}};
		dvm_addr[31:0] = dvm_word;
	end

	cca_snoop u_snoop (
		.clock_in       (clock_in),
		.rst_in         (rst_in),
		.enable_in      (coherent_out),
		.ac_valid_in    (ac_valid_in),
		.ac_snoop_in    (ac_snoop_in),
		.ac_addr_in     (ac_addr_in),
		.cr_ready_in    (cr_ready_in),
		.inval_done_in  (inval_done_in),
		.ac_ready_out   (ac_ready_out),
		.cr_valid_out   (cr_valid_out),
		.cr_resp_out    (cr_resp_out),
		.inval_req_out  (inval_req_out),
		.inval_addr_out (inval_addr_out),
		.dvm_seen_out   ()
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_IDLE: if (req_valid_in && coherent_out)
			nxt_state = !sel_legal ? ST_ACK : (sel_is_write ? ST_AW : ST_AR);
		ST_AR:   if (ar_ready_in) nxt_state = ST_R;
		ST_R:    if (r_valid_in && r_last_in) nxt_state = ST_ACK;
		ST_AW:   if ((aw_ready_in || !aw_valid_out) && (w_ready_in || !w_valid_out)) nxt_state = ST_B;
		ST_B:    if (b_valid_in) nxt_state = ST_ACK;
		ST_ACK:  nxt_state = ST_IDLE;
		default: nxt_state = ST_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// channel outputs
	// ---------------------------------------------------------------
	always @(posedge clock_in) begin
		if (rst_in) begin
			state_ff      <= ST_IDLE;
			coherent_out  <= 1'b0;
			req_ready_out <= 1'b0;
			req_done_out  <= 1'b0;
			req_rdata_out <= 32'h0000_0000;
			req_resp_out  <= 2'h0;
			ar_valid_out  <= 1'b0;
			ar_addr_out   <= {ADDR_SIZE{1'b0}};
			ar_snoop_out  <= 4'h0;
			ar_domain_out <= 2'h0;
			r_ready_out   <= 1'b0;
			r_ack_out     <= 1'b0;
			aw_valid_out  <= 1'b0;
			aw_addr_out   <= {ADDR_SIZE{1'b0}};
			aw_snoop_out  <= 3'h0;
			w_valid_out   <= 1'b0;
			w_data_out    <= 32'h0000_0000;
			w_strb_out    <= 4'h0;
			w_last_out    <= 1'b0;
			b_ready_out   <= 1'b0;
			w_ack_out     <= 1'b0;
		end else begin
			coherent_out  <= ENABLED;
			state_ff      <= nxt_state;
			req_ready_out <= 1'b0;
			req_done_out  <= 1'b0;
			r_ack_out     <= 1'b0;
			w_ack_out     <= 1'b0;
			case (state_ff)
			ST_IDLE: if (req_valid_in && coherent_out) begin
				req_ready_out <= 1'b1;
				req_resp_out  <= sel_legal ? 2'h0 : 2'h2;
				if (sel_legal && sel_is_write) begin
					aw_valid_out <= 1'b1;
					aw_addr_out  <= req_addr_in; // physical, untranslated
					aw_snoop_out <= `CCA_AW_WRITE_UNIQUE;
					w_valid_out  <= 1'b1;
					w_data_out   <= req_wdata_in;
					w_strb_out   <= req_wstrb_in;
					w_last_out   <= 1'b1;
				end else if (sel_legal) begin
					ar_valid_out  <= 1'b1;
					ar_snoop_out  <= sel_snoop;
					ar_domain_out <= (sel_snoop == `CCA_AR_DVM_MESSAGE || sel_snoop == `CCA_AR_DVM_COMPLETE) ?
						2'h1 : 2'h2;
					if (sel_snoop == `CCA_AR_DVM_MESSAGE)
						ar_addr_out <= dvm_addr;
					else
						ar_addr_out <= req_addr_in;
				end
			end
			ST_AR: if (ar_ready_in) begin
				ar_valid_out <= 1'b0;
				r_ready_out  <= 1'b1;
			end
			ST_R: if (r_valid_in) begin
				req_rdata_out <= r_data_in;
				req_resp_out  <= r_resp_in[1:0];
				if (r_last_in) begin
					r_ready_out <= 1'b0;
					r_ack_out   <= 1'b1;
				end
			end
			ST_AW: begin
				if (aw_ready_in)
					aw_valid_out <= 1'b0;
				if (w_ready_in) begin
					w_valid_out <= 1'b0;
					w_last_out  <= 1'b0;
				end
				if (nxt_state == ST_B)
					b_ready_out <= 1'b1;
			end
			ST_B: if (b_valid_in) begin
				b_ready_out  <= 1'b0;
				req_resp_out <= b_resp_in;
				w_ack_out    <= 1'b1;
			end
			ST_ACK: req_done_out <= 1'b1;
			default: ;
			endcase
		end
	end
endmodule // cca_port

/* verification/cca_port_properties.sv */
`timescale 1ns/100ps
`include "cca_defines.vh"

module cca_port_checker #(
	parameter INTERCONNECT_SEL = 3,
	parameter ADDR_SIZE        = 32
) (
	input logic                 clock_in,
	input logic                 rst_in,
	input logic                 cache_on_in,
	input logic                 inhibit_cache_in,
	input logic                 req_ready_out,
	input logic [3:0]           req_kind_in,
	input logic                 ar_valid_out,
	input logic [ADDR_SIZE-1:0] ar_addr_out,
	input logic [3:0]           ar_snoop_out,
	input logic                 aw_valid_out,
	input logic [2:0]           aw_snoop_out,
	input logic                 w_valid_out,
	input logic                 w_last_out,
	input logic                 ac_ready_out,
	input logic [3:0]           ac_snoop_in,
	input logic [63:0]          ac_addr_in,
	input logic                 inval_req_out,
	input logic [63:0]          inval_addr_out,
	input logic                 inval_done_in,
	input logic                 cr_valid_out,
	input logic [4:0]           cr_resp_out,
	input logic                 coherent_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// request kind is still held in the cycle that ready pulses
	wire [3:0] k    = req_kind_in;
	wire       tk   = req_ready_out;
	wire       ok_c = cache_on_in && !inhibit_cache_in;
	// ----------
	// request side
	// ----------
	property p_fill; tk && k == `CCA_REQ_FILL && ok_c |-> ar_valid_out
		&& ar_snoop_out == `CCA_AR_READ_CLEAN; endproperty
	a_fill: assert property (p_fill) else $error("fill snoop wrong");
	property p_once; tk && (k == `CCA_REQ_READ || k == `CCA_REQ_FILL && !ok_c) |->
		ar_snoop_out == `CCA_AR_READ_ONCE; endproperty
	a_once: assert property (p_once) else $error("uncached read snoop wrong");
	property p_swx; tk && k == `CCA_REQ_SWX |-> ar_valid_out && ar_snoop_out == `CCA_AR_CLEAN_UNIQUE; endproperty
	a_swx: assert property (p_swx) else $error("exclusive store snoop wrong");
	property p_store; tk && k == `CCA_REQ_STORE |-> aw_valid_out && w_valid_out && w_last_out
		&& aw_snoop_out == `CCA_AW_WRITE_UNIQUE; endproperty
	a_store: assert property (p_store) else $error("store not write unique");
	property p_inv; tk && (k == `CCA_REQ_FLUSH || k == `CCA_REQ_CLEAR) |-> ar_valid_out
		&& ar_snoop_out == (k == `CCA_REQ_FLUSH ? `CCA_AR_CLEAN_INVALID : `CCA_AR_MAKE_INVALID); endproperty
	a_inv: assert property (p_inv) else $error("flush or clear snoop wrong");
	property p_dvm; tk && k >= `CCA_REQ_TLBI && k <= `CCA_REQ_ICI_VA |-> ar_snoop_out == `CCA_AR_DVM_MESSAGE
		&& ar_addr_out[14:12] == k[2:0] - 3'h6; endproperty
	a_dvm: assert property (p_dvm) else $error("dvm operation type wrong");
	property p_fld; tk && (k == `CCA_REQ_TLBI || k == `CCA_REQ_ICI_PA || k == `CCA_REQ_ICI_VA) |->
		(k == `CCA_REQ_ICI_PA ? ar_addr_out[11:10] == 2'h3 : ar_addr_out[9:8] == 2'h2); endproperty
	a_fld: assert property (p_fld) else $error("dvm qualifier wrong");
	property p_sync; tk && k == `CCA_REQ_SYNC |-> ar_snoop_out == `CCA_AR_DVM_MESSAGE
		&& ar_addr_out[14:12] == 3'h4; endproperty
	a_sync: assert property (p_sync) else $error("dvm sync wrong");
	property p_cmpl; tk && k == `CCA_REQ_COMPLETE |-> ar_valid_out && ar_snoop_out == `CCA_AR_DVM_COMPLETE; endproperty
	a_cmpl: assert property (p_cmpl) else $error("dvm complete wrong");
	// ----------
	// snoop side
	// ----------
	property p_snp; ac_ready_out && (ac_snoop_in == 4'h9 || ac_snoop_in == 4'hd) |-> inval_req_out
		&& inval_addr_out == ac_addr_in && !cr_valid_out; endproperty
	a_snp: assert property (p_snp) else $error("snoop did not invalidate");
	property p_dvs; ac_ready_out && ac_snoop_in >= 4'he |-> !inval_req_out && cr_valid_out; endproperty
	a_dvs: assert property (p_dvs) else $error("dvm snoop answered wrongly");
	property p_cr; inval_req_out && inval_done_in |=> !inval_req_out && cr_valid_out && cr_resp_out == 5'h00; endproperty
	a_cr: assert property (p_cr) else $error("snoop response wrong");
	property p_coh; $fell(rst_in) && INTERCONNECT_SEL == 3 |=> coherent_out; endproperty
	a_coh: assert property (p_coh) else $error("coherent mode not entered");
endmodule // cca_port_checker

bind cca_port cca_port_checker #(.INTERCONNECT_SEL(INTERCONNECT_SEL), .ADDR_SIZE(ADDR_SIZE)) u_cca_port_checker (.*);

/* verification/cca_ace_model.sv */
`timescale 1ns/100ps

module cca_ace_model (
	input  wire        clock_in,
	input  wire        slow_in,
	input  wire        ar_valid_in,
	input  wire [31:0] ar_addr_in,
	output reg         ar_ready_out,
	output reg         r_valid_out,
	output reg  [31:0] r_data_out,
	output reg         r_last_out,
	input  wire        r_ready_in,
	input  wire        aw_valid_in,
	input  wire        w_valid_in,
	input  wire [31:0] w_data_in,
	output reg         aw_ready_out,
	output reg         w_ready_out,
	output reg         b_valid_out,
	input  wire        b_ready_in,
	output reg  [31:0] last_wdata_out
);
	// ----------
	// read side, single beat
	// ----------
	initial begin
		{ar_ready_out, r_valid_out, r_last_out} = 3'h0;
		r_data_out = 32'h0000_0000;
		forever begin
			@(posedge clock_in);
			if (ar_valid_in) begin
				repeat (slow_in ? 3 : 0) @(posedge clock_in);
				ar_ready_out <= 1'b1;
				@(posedge clock_in);
				ar_ready_out <= 1'b0;
				r_valid_out  <= 1'b1;
				r_last_out   <= 1'b1;
				r_data_out   <= ar_addr_in ^ 32'h5a5a_5a5a;
				do @(posedge clock_in); while (!r_ready_in);
				r_valid_out <= 1'b0;
				r_last_out  <= 1'b0;
				// released data is scrambled so a stale beat never looks valid
				r_data_out  <= ~r_data_out;
			end
		end
	end
	// ----------
	// write side
	// ----------
	initial begin
		{aw_ready_out, w_ready_out, b_valid_out} = 3'h0;
		last_wdata_out = 32'h0000_0000;
		forever begin
			@(posedge clock_in);
			if (aw_valid_in && w_valid_in) begin
				repeat (slow_in ? 2 : 0) @(posedge clock_in);
				aw_ready_out   <= 1'b1;
				w_ready_out    <= 1'b1;
				last_wdata_out <= w_data_in;
				@(posedge clock_in);
				aw_ready_out <= 1'b0;
				w_ready_out  <= 1'b0;
				b_valid_out  <= 1'b1;
				do @(posedge clock_in); while (!b_ready_in);
				b_valid_out <= 1'b0;
			end
		end
	end
endmodule // cca_ace_model

/* verification/cca_port_tb.sv */
`timescale 1ns/100ps
`include "cca_defines.vh"

module cca_port_tb;
	reg         clock_in, rst_in, cache_on_in, inhibit_cache_in, req_valid_in, slow;
	reg         ac_valid_in, cr_ready_in, inval_done_in;
	reg  [3:0]  req_kind_in, ac_snoop_in, req_wstrb_in;
	reg  [31:0] req_addr_in, req_wdata_in;
	reg  [63:0] ac_addr_in;
	wire [3:0]  r_resp_in = 4'h0;
	wire [1:0]  b_resp_in = 2'h0;
	wire        req_ready_out, req_done_out, ar_valid_out, ar_ready_in, r_valid_in, r_last_in, r_ready_out;
	wire        r_ack_out, aw_valid_out, aw_ready_in, w_valid_out, w_ready_in, w_last_out, b_valid_in;
	wire        b_ready_out, w_ack_out, ac_ready_out, cr_valid_out, inval_req_out, coherent_out;
	wire [1:0]  req_resp_out, ar_domain_out;
	wire [2:0]  aw_snoop_out;
	wire [3:0]  ar_snoop_out, w_strb_out;
	wire [4:0]  cr_resp_out;
	wire [31:0] req_rdata_out, ar_addr_out, r_data_in, aw_addr_out, w_data_out, last_wdata;
	wire [63:0] inval_addr_out;
	integer     err_count, samples_checked;
	integer     cycles = 0;
	integer     r_ack_count = 0, w_ack_count = 0;

	cca_port u_cca_port (.*);
	cca_ace_model u_cca_ace_model (.clock_in(clock_in), .slow_in(slow), .ar_valid_in(ar_valid_out),
		.ar_addr_in(ar_addr_out), .ar_ready_out(ar_ready_in), .r_valid_out(r_valid_in), .r_data_out(r_data_in),
		.r_last_out(r_last_in), .r_ready_in(r_ready_out), .aw_valid_in(aw_valid_out), .w_valid_in(w_valid_out),
		.w_data_in(w_data_out), .aw_ready_out(aw_ready_in), .w_ready_out(w_ready_in), .b_valid_out(b_valid_in),
		.b_ready_in(b_ready_out), .last_wdata_out(last_wdata));

	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// ----------
	// common tasks
	// ----------
	task chk(input [63:0] got, input [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function logic sig(input integer w);
		case (w)
			0: sig = req_ready_out;
			1: sig = req_done_out;
			2: sig = ac_ready_out;
			default: sig = cr_valid_out;
		endcase
	endfunction
	task wait_for(input integer w);
		integer n;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (sig(w) !== 1'b1 && n < 40);
		if (sig(w) !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: no handshake %0d", $time, w);
		end
	endtask
	task do_req(input [3:0] kind, input [31:0] addr, input [1:0] rsp);
		req_kind_in  <= kind;
		req_addr_in  <= addr;
		req_valid_in <= 1'b1;
		wait_for(0);
		req_valid_in <= 1'b0;
		wait_for(1);
		chk(req_resp_out, rsp);
	endtask
	task snoop(input [3:0] kind, input [63:0] addr, input inv);
		ac_snoop_in <= kind;
		ac_addr_in  <= addr;
		ac_valid_in <= 1'b1;
		wait_for(2);
		ac_valid_in <= 1'b0;
		chk(inval_req_out, inv);
		chk(cr_valid_out, !inv);
		if (inv) begin
			chk(inval_addr_out, addr);
			@(posedge clock_in);
			inval_done_in <= 1'b1;
			@(posedge clock_in);
			inval_done_in <= 1'b0;
		end
		wait_for(3);
		chk(cr_resp_out, 5'h00);
		cr_ready_in <= 1'b1;
		@(posedge clock_in);
		cr_ready_in <= 1'b0;
	endtask
	// ----------
	// scenarios
	// ----------
	task t_reads;
		integer i;
		for (i = 0; i < 8; i++) begin
			slow             <= i[2];
			cache_on_in      <= i[1:0] != 2'h1;
			inhibit_cache_in <= i[1:0] == 2'h2;
			do_req(i[1:0] == 2'h3 ? `CCA_REQ_READ : `CCA_REQ_FILL, 32'h0000_1000 + i * 32'h40, 2'h0);
			chk(req_rdata_out, req_addr_in ^ 32'h5a5a_5a5a);
		end
		chk(ar_domain_out, 2'h2);
		$display("t_reads done");
	endtask
	task t_data;
		integer k;
		req_wdata_in <= 32'hc0de_1234;
		for (k = 2; k < 6; k++)
			do_req(k[3:0], 32'h0000_2000 + k * 32'h4, 2'h0);
		chk(last_wdata, 32'hc0de_1234);
		chk(w_strb_out, 4'hf);
		chk(aw_addr_out, 32'h0000_200c);
		chk(w_ack_count, 1);
		$display("t_data done");
	endtask
	task t_dvm;
		integer k;
		slow <= 1'b0;
		for (k = 6; k < 12; k++)
			do_req(k[3:0], 32'h1234_5001, 2'h0);
		chk(ar_domain_out, 2'h1);
		chk(r_ack_count, 17);
		$display("t_dvm done");
	endtask
	task t_refuse;
		integer k;
		chk(coherent_out, 1'b1);
		for (k = 12; k < 16; k++)
			do_req(k[3:0], 32'h0000_3000, 2'h2);
		$display("t_refuse done");
	endtask
	task t_snoop;
		snoop(4'h9, 64'h0000_0040_0000_1040, 1'b1);
		snoop(4'hd, 64'h0000_0000_0000_2080, 1'b1);
		snoop(4'hf, 64'h0000_0000_0000_4001, 1'b0);
		$display("t_snoop done");
	endtask

	// acknowledge pulses counted once out of reset
	always @(posedge clock_in) begin
		if (!rst_in) begin
			r_ack_count <= r_ack_count + r_ack_out;
			w_ack_count <= w_ack_count + w_ack_out;
		end
	end

	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			$display("CHECK FAILED at %0t: run timeout", $time);
			close_out;
		end
	end

	initial begin
		{rst_in, cache_on_in, inhibit_cache_in, req_valid_in} = 4'h8;
		{slow, ac_valid_in, cr_ready_in, inval_done_in} = 4'h0;
		req_kind_in = 4'h0;
		ac_snoop_in = 4'h0;
		req_wstrb_in = 4'hf;
		req_addr_in = 32'h0000_0000;
		req_wdata_in = 32'h0000_0000;
		ac_addr_in = 64'h0000_0000_0000_0000;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		t_reads;
		t_data;
		t_dvm;
		t_refuse;
		t_snoop;
		close_out;
	end
endmodule // cca_port_tb
